//--- pic_regs.svh
`ifndef PIC_REGS_SVH
`define PIC_REGS_SVH

// register byte offsets on the apb bus
`define PIC_OFF_PEND      12'h000
`define PIC_OFF_CLEAR     12'h004
`define PIC_OFF_MASK      12'h008
`define PIC_OFF_LATCH     12'h00C
`define PIC_OFF_MODE      12'h010
`define PIC_OFF_TRIG0     12'h014
`define PIC_OFF_TRIG1     12'h018

// field positions
`define PIC_FWD_MASK_BIT  0
`define PIC_RELEASE_BIT   4
`define PIC_CH_LO         1
`define PIC_CH_HI         15

// reset values
`define PIC_PEND_RST      16'h0000
`define PIC_MASK_RST      16'hFFFF
`define PIC_TRIG0_RST     16'h0000
`define PIC_TRIG1_RST     14'h0000
`define PIC_LEVEL_RST     4'h0

// synchroniser depth for pins
`define PIC_SYNC_STAGES   3

`endif

//--- pic_pkg.sv
package pic_pkg;

  // per-channel detection mode
  typedef enum logic [1:0] {
    PIC_TRIG_HIGH = 2'b00,
    PIC_TRIG_LOW  = 2'b01,
    PIC_TRIG_RISE = 2'b10,
    PIC_TRIG_FALL = 2'b11
  } pic_trig_type;

  // controller operating mode
  typedef enum logic [1:0] {
    PIC_MODE_BYPASS = 2'b00,
    PIC_MODE_ENABLE = 2'b01,
    PIC_MODE_RSV2   = 2'b10,
    PIC_MODE_RSV3   = 2'b11
  } pic_mode_type;

endpackage : pic_pkg

//--- pic_sync.sv
`timescale 1ns/1ps
`include "pic_regs.svh"

module pic_sync #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // raw pins and filtered result
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] filt_out
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] filt_ff;
  logic [W-1:0] nxt_filt;

  // a bit follows the pin once the second and third stage agree
  assign nxt_filt = (s2_ff & s3_ff) | (filt_ff & (s2_ff ^ s3_ff));
  assign filt_out = filt_ff;

  // three-stage chain; s1 feeds only s2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff   <= '0;
      s2_ff   <= '0;
      s3_ff   <= '0;
      filt_ff <= '0;
    end else begin
      s1_ff   <= pin_in;
      s2_ff   <= s1_ff;
      s3_ff   <= s2_ff;
      filt_ff <= nxt_filt;
    end
  end

endmodule : pic_sync

//--- pic_top.sv
`timescale 1ns/1ps
`include "pic_regs.svh"

// What this block does
// - two-bit mode: high, low, rise, fall
// - pending flags in bits 15..1, reset zero
// - pending bit 0 and bits 31..16 read zero
// - detected trigger sets sticky pending flag
// - pending register read-only, writes ignored
// - mode 00 passes external level straight through
// - mode 01 turns level pins into channels
// - highest unmasked pending channel goes to latch
// - latch forwarded only while forward mask clear
// - release write clears latch for next level
// - pending levels reload latch in priority order
// - all mask bits set at reset
// - clear register ones clear pending flags
// - forward mask set: latch still loads, no trap
// - masked channels still set readable pending flags
// - two trigger registers: 8..15 and 1..7
// - pinless channels tied low internally
// - fifteen levels; level 15 core-unmaskable
module pic_top (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // request pins
  input  wire logic [3:0]  ext_level_in,
  input  wire logic [3:0]  req_pin_mid,
  // to integer unit
  output logic      [3:0]  core_level
);

  logic [31:0]              prdata_ff;
  logic                     pready_ff;
  logic                     pslverr_ff;
  logic [15:0]              pend_ff;
  logic [15:0]              mask_ff;
  logic [15:0]              trig0_ff;
  logic [13:0]              trig1_ff;
  logic [3:0]               latch_ff;
  logic [3:0]               core_level_ff;
  logic [15:0]              prev_ff;
  pic_pkg::pic_mode_type    mode_ff;
  logic [7:0]               pin_filt;
  logic [15:0]              req_vec;
  logic [15:0]              det_vec;
  logic [15:0]              nxt_pend;
  logic [15:0]              unmasked;
  logic [3:0]               top_level;
  logic [3:0]               nxt_latch;
  logic [3:0]               nxt_core_level;
  logic [31:0]              rd_mux;
  logic                     addr_ok;
  logic                     acc_go;
  logic                     wr_go;
  logic                     hit_pend;
  logic                     hit_clear;
  logic                     hit_mask;
  logic                     hit_latch;
  logic                     hit_mode;
  logic                     hit_trig0;
  logic                     hit_trig1;
  logic                     clr_hit;
  logic                     release_hit;
  logic                     ctl_enabled;

  // pins cross into the core clock through three stages
  pic_sync #(
    .W(8)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .pin_in   ({req_pin_mid, ext_level_in}),
    .filt_out (pin_filt)
  );

  // bus outputs come from flip-flops
  assign prdata   = prdata_ff;
  assign pready   = pready_ff;
  assign pslverr  = pslverr_ff;
  assign core_level = core_level_ff;

  // address decode
  assign hit_pend  = (paddr == `PIC_OFF_PEND);
  assign hit_clear = (paddr == `PIC_OFF_CLEAR);
  assign hit_mask  = (paddr == `PIC_OFF_MASK);
  assign hit_latch = (paddr == `PIC_OFF_LATCH);
  assign hit_mode  = (paddr == `PIC_OFF_MODE);
  assign hit_trig0 = (paddr == `PIC_OFF_TRIG0);
  assign hit_trig1 = (paddr == `PIC_OFF_TRIG1);
  assign addr_ok   = hit_pend | hit_clear | hit_mask | hit_latch |
                     hit_mode | hit_trig0 | hit_trig1;

  // a write takes effect on the edge that samples pready high
  assign acc_go      = psel & penable & ~pready_ff;
  assign wr_go       = psel & penable & pready_ff & pwrite & addr_ok;
  assign clr_hit     = wr_go & hit_clear;
  assign release_hit = wr_go & hit_latch & pwdata[`PIC_RELEASE_BIT];
  assign ctl_enabled = (mode_ff == pic_pkg::PIC_MODE_ENABLE);

  // read data; reserved and write-only bits read zero
  assign rd_mux =
    hit_pend  ? {16'h0000, pend_ff[15:1], 1'b0} :
    hit_mask  ? {16'h0000, mask_ff} :
    hit_latch ? {28'h000_0000, latch_ff} :
    hit_mode  ? {30'h0000_0000, mode_ff} :
    hit_trig0 ? {16'h0000, trig0_ff} :
    hit_trig1 ? {18'h0_0000, trig1_ff} :
                32'h0000_0000;

  // request sources: pins only while enabled, pinless tied low
  assign req_vec[0]     = 1'b0;
  assign req_vec[7:1]   = 7'h00;
  assign req_vec[11:8]  = ctl_enabled ? pin_filt[7:4] : 4'h0;
  assign req_vec[15:12] = ctl_enabled ? pin_filt[3:0] : 4'h0;

  // per-channel trigger select and detection
  assign det_vec[0] = 1'b0;
  for (genvar c = `PIC_CH_LO; c <= `PIC_CH_HI; c++) begin : g_ch
    logic [1:0] tmode;
    if (c >= 8) begin : g_hi
      assign tmode = trig0_ff[2*(c-8) +: 2];
    end else begin : g_lo
      assign tmode = trig1_ff[2*(c-1) +: 2];
    end
    // edges compare against the previous clock sample
    assign det_vec[c] =
      (tmode == pic_pkg::PIC_TRIG_HIGH) ?  req_vec[c] :
      (tmode == pic_pkg::PIC_TRIG_LOW)  ? ~req_vec[c] :
      (tmode == pic_pkg::PIC_TRIG_RISE) ?
        (req_vec[c] & ~prev_ff[c]) :
        (~req_vec[c] & prev_ff[c]);
  end

  // set wins over clear; bit 0 holds nothing
  assign nxt_pend = ((pend_ff & ~(clr_hit ? pwdata[15:0] : 16'h0000))
                    | det_vec) & 16'hFFFE;

  // priority: highest channel number wins
  assign unmasked = pend_ff & ~{mask_ff[15:1], 1'b1};

  function automatic logic [3:0] pic_top_ch(input logic [15:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = `PIC_CH_LO; i <= `PIC_CH_HI; i++) begin
      if (v[i]) begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : pic_top_ch

  assign top_level = pic_top_ch(unmasked);

  // latch loads only when empty, release empties it
  assign nxt_latch =
    release_hit                                ? 4'h0 :
    (latch_ff == 4'h0 && ctl_enabled)          ? top_level :
                                                 latch_ff;

  // level to the integer unit
  assign nxt_core_level =
    (mode_ff == pic_pkg::PIC_MODE_BYPASS)      ? pin_filt[3:0] :
    (ctl_enabled && !mask_ff[`PIC_FWD_MASK_BIT]) ? latch_ff :
                                                 4'h0;

  // apb answer: pready one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end else begin
      pready_ff  <= acc_go;
      pslverr_ff <= acc_go & ~addr_ok;
      prdata_ff  <= (acc_go & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // software-written control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff  <= `PIC_MASK_RST;
      trig0_ff <= `PIC_TRIG0_RST;
      trig1_ff <= `PIC_TRIG1_RST;
      mode_ff  <= pic_pkg::PIC_MODE_BYPASS;
    end else if (wr_go) begin
      if (hit_mask) begin
        mask_ff <= pwdata[15:0];
      end
      if (hit_trig0) begin
        trig0_ff <= pwdata[15:0];
      end
      if (hit_trig1) begin
        trig1_ff <= pwdata[13:0];
      end
      if (hit_mode) begin
        mode_ff <= pic_pkg::pic_mode_type'(pwdata[1:0]);
      end
    end
  end

  // pending flags, level latch, edge history and core level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff     <= `PIC_PEND_RST;
      latch_ff    <= `PIC_LEVEL_RST;
      prev_ff     <= 16'h0000;
      core_level_ff <= `PIC_LEVEL_RST;
    end else begin
      pend_ff     <= nxt_pend;
      latch_ff    <= nxt_latch;
      prev_ff     <= req_vec;
      core_level_ff <= nxt_core_level;
    end
  end

  // detected events appear in the pending flags next cycle
  pend_set_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (|det_vec) |=> ((pend_ff & $past(det_vec)) == $past(det_vec)))
    else $error("detected event did not set its pending flag");

  // reserved pending bits read zero
  pend_rsv_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (acc_go && !pwrite && hit_pend) |=>
      (prdata_ff[0] == 1'b0 && prdata_ff[31:16] == 16'h0000))
    else $error("reserved pending bits read non-zero");

  // pending changes only through detection or clearing
  pend_ro_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pend_ff != $past(pend_ff)) |->
      ($past(|det_vec) || $past(clr_hit)))
    else $error("pending flags changed without cause");

  // clear ones drop flags that saw no new event
  pend_clr_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (clr_hit && det_vec == 16'h0000) |=>
      ((pend_ff & $past(pwdata[15:0])) == 16'h0000))
    else $error("request clear left a flag set");

  // bypass passes the synchronised external level
  bypass_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (mode_ff == pic_pkg::PIC_MODE_BYPASS) |=>
      (core_level_ff == $past(pin_filt[3:0])))
    else $error("bypass level not passed through");

  // forward mask silences the core level
  fwd_mask_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctl_enabled && mask_ff[`PIC_FWD_MASK_BIT]) ##1
      (ctl_enabled && mask_ff[`PIC_FWD_MASK_BIT]) |->
      (core_level_ff == 4'h0))
    else $error("level forwarded while forward mask set");

  // a held level stays until released
  latch_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (latch_ff != 4'h0 && !release_hit) |=> $stable(latch_ff))
    else $error("held level overwritten before release");

  // release empties the latch
  release_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    release_hit |=> (latch_ff == 4'h0))
    else $error("release did not clear the level latch");

  // an empty latch loads the winning channel
  load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (latch_ff == 4'h0 && ctl_enabled && !release_hit) |=>
      (latch_ff == $past(top_level)))
    else $error("latch not loaded with highest pending level");

  // masks all set after reset
  mask_rst_a: assert property (
    @(posedge pclk) $rose(presetn) |-> (mask_ff == `PIC_MASK_RST))
    else $error("channel masks not all set after reset");

  // an open forward mask passes the held level to the core
  fwd_pass_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    (ctl_enabled && !mask_ff[`PIC_FWD_MASK_BIT]) |=>
      (core_level_ff == $past(latch_ff)))
    else $error("held level not forwarded to the core");

endmodule : pic_top

//--- pic_iu_model.sv
`timescale 1ns/1ps

// integer unit stand-in: samples the level it is offered each cycle
module pic_core_model (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // level from the controller
  input  wire logic [3:0] core_level,
  output logic      [3:0] seen_level_ff
);
  // a non-zero value would raise a trap; level 15 is unmaskable here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_level_ff <= 4'h0;
    end else begin
      seen_level_ff <= core_level;
    end
  end
endmodule : pic_core_model

//--- priority_interrupt_controller_test.sv
`timescale 1ns/1ps

module priority_interrupt_controller_test;
  // bench signals
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic [3:0]  ext_level_in, req_pin_mid, core_level, seen_level;
  int          n_fail, total_checks;

  pic_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_level_in(ext_level_in), .req_pin_mid(req_pin_mid),
    .core_level(core_level));
  pic_core_model core_u (.pclk(pclk), .presetn(presetn),
    .core_level(core_level), .seen_level_ff(seen_level));

  // clock generation
  always #10 pclk = ~pclk;

  task report_and_stop;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : report_and_stop

  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  // one apb transfer, held until pready is sampled high
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_fail++;
      report_and_stop();
    end
  endtask : apb

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rd_chk

  // main sequence
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    ext_level_in = 4'h0;
    req_pin_mid = 4'h0;
    n_fail = 0;
    total_checks = 0;
    idle(4);
    presetn <= 1'b1;
    // reset values
    rd_chk(12'h000, 32'h0000_0000);
    rd_chk(12'h008, 32'h0000_ffff);
    rd_chk(12'h014, 32'h0000_0000);
    rd_chk(12'h018, 32'h0000_0000);
    // bypass passes pins straight to the core
    ext_level_in <= 4'ha;
    idle(7);
    check(core_level, 4'ha);
    check(seen_level, 4'ha);
    // pending is read only; unmapped offset errors
    apb(1'b1, 12'h000, 32'hffff_ffff);
    rd_chk(12'h000, 32'h0000_0000);
    check(err, 1'b0);
    rd_chk(12'h01c, 32'h0000_0000);
    check(err, 1'b1);
    ext_level_in <= 4'h0;
    // modes before enabling; only mode 01 ever written
    apb(1'b1, 12'h018, 32'h0000_0010);
    apb(1'b1, 12'h014, 32'h0000_0008);
    apb(1'b1, 12'h004, 32'h0000_fffe);
    apb(1'b1, 12'h010, 32'h0000_0001);
    idle(6);
    // tied-low channel 3 in low mode pends while masked
    rd_chk(12'h000, 32'h0000_0008);
    rd_chk(12'h00c, 32'h0000_0000);
    apb(1'b1, 12'h018, 32'h0000_0000);
    apb(1'b1, 12'h004, 32'h0000_0008);
    rd_chk(12'h000, 32'h0000_0000);
    // rising edge on channel 9 is sticky
    req_pin_mid <= 4'h2;
    idle(3);
    req_pin_mid <= 4'h0;
    idle(6);
    rd_chk(12'h000, 32'h0000_0200);
    apb(1'b1, 12'h008, 32'h0000_fdfe);
    idle(4);
    rd_chk(12'h00c, 32'h0000_0009);
    check(core_level, 4'h9);
    // higher channel 13 must wait for release
    ext_level_in <= 4'h2;
    apb(1'b1, 12'h008, 32'h0000_ddfe);
    idle(7);
    rd_chk(12'h000, 32'h0000_2200);
    rd_chk(12'h00c, 32'h0000_0009);
    apb(1'b1, 12'h004, 32'h0000_0200);
    apb(1'b1, 12'h00c, 32'h0000_0010);
    idle(4);
    rd_chk(12'h00c, 32'h0000_000d);
    check(core_level, 4'hd);
    // forward mask set: latch kept, nothing to the core
    apb(1'b1, 12'h008, 32'h0000_ddff);
    idle(3);
    check(core_level, 4'h0);
    check(seen_level, 4'h0);
    rd_chk(12'h00c, 32'h0000_000d);
    rd_chk(12'h000, 32'h0000_2000);
    // falling edge on channel 8; rising pin alone must not pend
    apb(1'b1, 12'h014, 32'h0000_0003);
    req_pin_mid <= 4'h1;
    idle(6);
    rd_chk(12'h000, 32'h0000_2000);
    req_pin_mid <= 4'h0;
    idle(8);
    rd_chk(12'h000, 32'h0000_2100);
    // channels 13 and 8 both unmasked: 13 wins the reload
    apb(1'b1, 12'h008, 32'h0000_dcff);
    apb(1'b1, 12'h004, 32'h0000_2000);
    rd_chk(12'h000, 32'h0000_2100);
    apb(1'b1, 12'h00c, 32'h0000_0010);
    idle(3);
    rd_chk(12'h00c, 32'h0000_000d);
    // drop channel 13, acknowledge, channel 8 follows
    ext_level_in <= 4'h0;
    idle(6);
    apb(1'b1, 12'h004, 32'h0000_2000);
    apb(1'b1, 12'h00c, 32'h0000_0010);
    idle(3);
    rd_chk(12'h00c, 32'h0000_0008);
    rd_chk(12'h000, 32'h0000_0100);
    check(core_level, 4'h0);
    report_and_stop();
  end
endmodule : priority_interrupt_controller_test
